/* inc/ptpc_pkg.sv */
// package for the periodic timer: register map, field positions, reset values
// assumes a 32-bit apb slave with word-aligned registers
package ptpc_pkg;
    localparam int CNT_W = 10;
    localparam logic [11:0] OFS_CTRL = 12'h000;
    localparam logic [11:0] OFS_CMPA = 12'h004;
    localparam logic [11:0] OFS_PER = 12'h008;
    localparam logic [11:0] OFS_CNT = 12'h00C;
    localparam logic [11:0] OFS_FLAG = 12'h010;
    // control register field positions
    localparam int CTL_CLR_SRC = 0;
    localparam int CTL_CAP_SRC = 1;
    localparam int CTL_INVERT = 2;
    localparam int CTL_LEVEL = 3;
    localparam int CTL_PIN_LO = 4;
    localparam int CTL_PIN_HI = 5;
    localparam int CTL_MODE_LO = 6;
    localparam int CTL_MODE_HI = 7;
    localparam int CTL_RUN = 8;
    localparam int FLG_A = 0;
    localparam int FLG_P = 1;
    localparam logic [1:0] MODE_CMP = 2'h0;
    localparam logic [1:0] MODE_CAP = 2'h1;
    localparam logic [1:0] MODE_PWM = 2'h2;
    localparam logic [1:0] MODE_TMR = 2'h3;
    localparam logic [1:0] PIN_LOW = 2'h0;
    localparam logic [1:0] PIN_HIGH = 2'h1;
    localparam logic [1:0] PIN_NONE = 2'h3;
    localparam logic [CNT_W-1:0] CNT_MAX = 10'h3FF;
    localparam logic [CNT_W-1:0] CNT_ZERO = 10'h000;
    localparam logic [8:0] CTRL_RST = 9'h000;
    localparam logic [31:0] RDATA_ZERO = 32'h00000000;
endpackage : ptpc_pkg

/* hdl/ptpc_edge.sv */
// edge detector for one synchronous input
// assumes the input is already synchronous to clk
`timescale 1ns/1ps
module ptpc_edge
    import ptpc_pkg::*;
(
    input wire logic clk,
    input wire logic arst_n,
    input wire logic din,
    output logic rise,
    output logic fall
);
    typedef struct packed {
        logic prev;
    } ptpc_edge_st_t;
    ptpc_edge_st_t st, next_st;
    always_comb begin
        next_st = st;
        next_st.prev = din;
    end
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            st <= '0;
        end else begin
            st <= next_st;
        end
    end
    assign rise = din & ~st.prev;
    assign fall = ~din & st.prev;
endmodule : ptpc_edge

/* hdl/ptpc_apb.sv */
// apb slave decode: access strobes and the unmapped-address error
// assumes the top decodes addresses and supplies read data
`timescale 1ns/1ps
module ptpc_apb
    import ptpc_pkg::*;
(
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic hit,
    output logic wr_stb,
    output logic rd_stb,
    output logic err
);
    // the top adds one wait state and registers pready, pslverr and read data
    assign wr_stb = psel & penable & pwrite & hit;
    assign rd_stb = psel & penable & ~pwrite & hit;
    assign err = psel & penable & ~hit;
endmodule : ptpc_apb

/* hdl/ptpc_timer.sv */
// periodic timer: compare, pwm, single pulse, capture and timer modes
// assumes apb master on CLK and pins synchronous to CLK
// Overview of operation
// - mode field 11 selects timer/counter mode
// - timer mode counts like compare mode, output pin unused
// - mode 10 with pin action not 11 selects pwm
// - pwm clears on period match; period 0 gives 1024 counts
// - compare-a sets duty; at or above period gives full duty
// - pwm raises flag a on a-match, flag p on period match
// - level bit picks polarity; pin action enables or forces pin
// - invert bit inverts driven pwm waveform
// - pwm counting continues while pin is forced
// - pwm ignores clear-source bit
// - run rising starts counter and pulse leading edge
// - trigger pin rising edge sets run in single pulse
// - a-match or software clear of run ends pulse
// - each a-match in single pulse raises interrupt flag
// - single pulse counter zeroed only at run rise; no period
// - mode 01 is capture; counter starts on run rise
// - capture source bit picks capture pin or trigger pin
// - pin action picks rise, fall, both; 11 disables capture
// - capture copies counter into compare-a and raises flag
// - capture counter free runs, clears on period match with flag
// - capture ignores clear source, level, invert; no output
// - compare counting clears on a-match if clear-source high
// - period zero lets counter wrap at 3FF
//
// The address map and the APB slave port were chosen for this implementation.
`timescale 1ns/1ps
module ptpc_timer
    import ptpc_pkg::*;
(
    input wire logic CLK,
    input wire logic ARST_N,
    input wire logic PSEL,
    input wire logic PENABLE,
    input wire logic PWRITE,
    input wire logic [11:0] PADDR,
    input wire logic [31:0] PWDATA,
    output logic [31:0] PRDATA,
    output logic PREADY,
    output logic PSLVERR,
    input wire logic EXT_TRIGGER_PIN,
    input wire logic CAPTURE_INPUT_PIN,
    output logic TIMER_OUT,
    output logic TIMER_OUT_EN
);
    typedef struct packed {
        logic [8:0] ctrl;
        logic [CNT_W-1:0] cmpa;
        logic [CNT_W-1:0] per;
        logic [CNT_W-1:0] cnt;
        logic flag_a;
        logic flag_p;
        logic run_q;
        logic out;
        logic out_en;
        logic [31:0] prdata;
        logic pslverr;
        logic pready;
    } ptpc_st_t;

    ptpc_st_t st, next_st;
    logic trg_rise, trg_fall, cap_rise, cap_fall;
    logic hit, wr_stb, rd_stb, err;
    logic [1:0] mode, pin;
    logic run, pulse_mode, pwm_mode, cmp_like;
    logic run_rise, match_a, match_p, wrap, sel_rise, sel_fall, cap_evt;
    logic active, wave;
    logic [CNT_W:0] period_len;
    logic wr_go, pwm_end;
    logic [CNT_W-1:0] per_last;

    ptpc_edge u_trg (
        .clk(CLK),
        .arst_n(ARST_N),
        .din(EXT_TRIGGER_PIN),
        .rise(trg_rise),
        .fall(trg_fall)
    );
    ptpc_edge u_cap (
        .clk(CLK),
        .arst_n(ARST_N),
        .din(CAPTURE_INPUT_PIN),
        .rise(cap_rise),
        .fall(cap_fall)
    );

    assign hit = (PADDR == OFS_CTRL) || (PADDR == OFS_CMPA) || (PADDR == OFS_PER) ||
                 (PADDR == OFS_CNT) || (PADDR == OFS_FLAG);
    ptpc_apb u_apb (
        .psel(PSEL),
        .penable(PENABLE),
        .pwrite(PWRITE),
        .hit(hit),
        .wr_stb(wr_stb),
        .rd_stb(rd_stb),
        .err(err)
    );

    assign mode = st.ctrl[CTL_MODE_HI:CTL_MODE_LO];
    assign pin = st.ctrl[CTL_PIN_HI:CTL_PIN_LO];
    assign run = st.ctrl[CTL_RUN];
    assign pwm_mode = (mode == MODE_PWM) && (pin != PIN_NONE);
    assign pulse_mode = (mode == MODE_PWM) && (pin == PIN_NONE);
    // timer mode shares the compare path
    assign cmp_like = (mode == MODE_CMP) || (mode == MODE_TMR);
    assign run_rise = run & ~st.run_q;
    assign match_a = run && (st.cnt == st.cmpa);
    assign match_p = run && (st.cnt == st.per) && (st.per != CNT_ZERO);
    assign wrap = run && (st.cnt == CNT_MAX);
    // pwm ends one count early so the period spans exactly the period value
    // a period value of 0 ends at 3FF, giving 1024 counts
    assign per_last = st.per - 10'h001;
    assign pwm_end = run && (st.cnt == per_last);
    // writes land only at the edge where pready is seen high
    assign wr_go = wr_stb & st.pready;
    assign sel_rise = st.ctrl[CTL_CAP_SRC] ? trg_rise : cap_rise;
    assign sel_fall = st.ctrl[CTL_CAP_SRC] ? trg_fall : cap_fall;
    always_comb begin
        unique case (pin)
            2'h0: cap_evt = sel_rise;
            2'h1: cap_evt = sel_fall;
            2'h2: cap_evt = sel_rise | sel_fall;
            2'h3: cap_evt = 1'b0;
        endcase
    end
    assign period_len = (st.per == CNT_ZERO) ? {1'b1, CNT_ZERO} : {1'b0, st.per};
    // full duty when compare-a reaches the period
    assign active = ({1'b0, st.cmpa} >= period_len) || (st.cnt < st.cmpa);
    assign wave = st.ctrl[CTL_LEVEL] ? active : ~active;

    always_comb begin
        next_st = st;
        next_st.run_q = run;
        // one wait state so that error and read data come from flops with pready
        next_st.pready = PSEL & PENABLE & ~st.pready;
        next_st.pslverr = err & ~st.pready;
        next_st.prdata = RDATA_ZERO;
        // software flag clears go first so that a hardware set below wins
        if (wr_go && (PADDR == OFS_FLAG)) begin
            next_st.flag_a = st.flag_a & ~PWDATA[FLG_A];
            next_st.flag_p = st.flag_p & ~PWDATA[FLG_P];
        end
        if (rd_stb && !st.pready) begin
            unique case (PADDR)
                OFS_CTRL: next_st.prdata = {23'h000000, st.ctrl};
                OFS_CMPA: next_st.prdata = {22'h000000, st.cmpa};
                OFS_PER: next_st.prdata = {22'h000000, st.per};
                OFS_CNT: next_st.prdata = {22'h000000, st.cnt};
                default: next_st.prdata = {30'h00000000, st.flag_p, st.flag_a};
            endcase
        end
        // counting; counter holds while run is low
        if (run_rise) begin
            // restart from zero on run rise
            next_st.cnt = CNT_ZERO;
        end else if (run) begin
            next_st.cnt = st.cnt + 10'h001;
            if (cmp_like) begin
                if (st.ctrl[CTL_CLR_SRC]) begin
                    if (match_a) begin
                        next_st.cnt = CNT_ZERO;
                    end
                    if (match_a && st.cmpa != CNT_ZERO) begin
                        next_st.flag_a = 1'b1;
                    end
                end else begin
                    // period zero wraps naturally at 3FF
                    if (match_p) begin
                        next_st.cnt = CNT_ZERO;
                        next_st.flag_p = 1'b1;
                    end
                    if (match_a && st.cmpa != CNT_ZERO) begin
                        next_st.flag_a = 1'b1;
                    end
                end
            end else if (mode == MODE_PWM && !pulse_mode) begin
                if (pwm_end) begin
                    next_st.cnt = CNT_ZERO;
                    next_st.flag_p = 1'b1;
                end
                if (match_a) begin
                    next_st.flag_a = 1'b1;
                end
            end else if (pulse_mode) begin
                // a-match ends pulse and raises flag
                if (match_a) begin
                    next_st.ctrl[CTL_RUN] = 1'b0;
                    next_st.flag_a = 1'b1;
                end
            end else begin
                // capture free run, period clear with flag
                if (match_p) begin
                    next_st.cnt = CNT_ZERO;
                    next_st.flag_p = 1'b1;
                end
            end
        end
        if (mode == MODE_CAP && run && cap_evt) begin
            next_st.cmpa = st.cnt;
            next_st.flag_a = 1'b1;
        end
        if (pulse_mode && !run && trg_rise) begin
            next_st.ctrl[CTL_RUN] = 1'b1;
        end
        // software writes; the counter is read-only and flags were handled above
        if (wr_go) begin
            unique case (PADDR)
                OFS_CTRL: next_st.ctrl = PWDATA[8:0];
                OFS_CMPA: next_st.cmpa = PWDATA[9:0];
                OFS_PER: next_st.per = PWDATA[9:0];
                default: begin
                end
            endcase
        end
        // output pin behaviour
        next_st.out_en = 1'b0;
        next_st.out = 1'b0;
        if (pwm_mode) begin
            // counting above keeps going while the pin is forced
            next_st.out_en = 1'b1;
            unique case (pin)
                PIN_LOW: next_st.out = 1'b0;
                PIN_HIGH: next_st.out = 1'b1;
                default: next_st.out = wave ^ st.ctrl[CTL_INVERT];
            endcase
        end else if (pulse_mode) begin
            // pulse is active while run is high
            next_st.out_en = 1'b1;
            next_st.out = (run ? st.ctrl[CTL_LEVEL] : ~st.ctrl[CTL_LEVEL]) ^
                st.ctrl[CTL_INVERT];
        end
        // timer and capture modes leave the pin undriven
    end

    always_ff @(posedge CLK or negedge ARST_N) begin
        if (!ARST_N) begin
            st <= '0;
        end else begin
            st <= next_st;
        end
    end

    assign PRDATA = st.prdata;
    assign PREADY = st.pready;
    assign PSLVERR = st.pslverr;
    assign TIMER_OUT = st.out;
    assign TIMER_OUT_EN = st.out_en;

    a_pulse_stop: assert property (@(posedge CLK) disable iff (!ARST_N)
        pulse_mode && match_a && !run_rise && !wr_stb |=> !run)
        else $error("pulse did not stop on compare a");
    a_cap_copy: assert property (@(posedge CLK) disable iff (!ARST_N)
        mode == MODE_CAP && run && cap_evt && !wr_stb |=> st.cmpa == $past(st.cnt))
        else $error("capture value not copied");
    a_run_restart: assert property (@(posedge CLK) disable iff (!ARST_N)
        run_rise |=> st.cnt == CNT_ZERO)
        else $error("counter not zeroed at start");
    a_trig_start: assert property (@(posedge CLK) disable iff (!ARST_N)
        pulse_mode && !run && trg_rise && !wr_stb |=> run)
        else $error("trigger did not start pulse");
    a_pwm_flagp: assert property (@(posedge CLK) disable iff (!ARST_N)
        pwm_mode && pwm_end && !run_rise && !wr_stb |=> st.flag_p && st.cnt == CNT_ZERO)
        else $error("pwm period match lost");
    a_cap_noout: assert property (@(posedge CLK) disable iff (!ARST_N)
        mode == MODE_CAP ##1 mode == MODE_CAP |-> !TIMER_OUT_EN)
        else $error("capture mode drives pin");
    a_tmr_noout: assert property (@(posedge CLK) disable iff (!ARST_N)
        mode == MODE_TMR ##1 mode == MODE_TMR |-> !TIMER_OUT_EN)
        else $error("timer mode drives pin");
    a_pwm_force: assert property (@(posedge CLK) disable iff (!ARST_N)
        pwm_mode && pin == PIN_HIGH |=> TIMER_OUT == 1'b1 || !$past(pwm_mode, 1))
        else $error("forced high not seen");
    a_wrap_max: assert property (@(posedge CLK) disable iff (!ARST_N)
        cmp_like && wrap && st.per == CNT_ZERO && !st.ctrl[CTL_CLR_SRC] && !run_rise
        && !wr_stb |=> st.cnt == CNT_ZERO)
        else $error("counter did not wrap");
    a_pwm_flaga: assert property (@(posedge CLK) disable iff (!ARST_N)
        pwm_mode && match_a && !run_rise |=> st.flag_a)
        else $error("pwm compare a flag lost");
    a_full_duty: assert property (@(posedge CLK) disable iff (!ARST_N)
        pwm_mode && pin == 2'h2 && ({1'b0, st.cmpa} >= period_len)
        |=> TIMER_OUT == $past(st.ctrl[CTL_LEVEL] ^ st.ctrl[CTL_INVERT]))
        else $error("full duty not held");
    a_pwm_low: assert property (@(posedge CLK) disable iff (!ARST_N)
        pwm_mode && pin == PIN_LOW |=> !TIMER_OUT && TIMER_OUT_EN)
        else $error("forced low not seen");
    a_cap_hold: assert property (@(posedge CLK) disable iff (!ARST_N)
        mode == MODE_CAP && pin == PIN_NONE && !wr_stb |=> st.cmpa == $past(st.cmpa))
        else $error("capture taken while disabled");
    a_clr_noflagp: assert property (@(posedge CLK) disable iff (!ARST_N)
        cmp_like && st.ctrl[CTL_CLR_SRC] && !st.flag_p |=> !st.flag_p)
        else $error("period flag raised with clear on a");
    c_pulse: cover property (@(posedge CLK) pulse_mode && match_a);
    c_capture: cover property (@(posedge CLK) mode == MODE_CAP && cap_evt && run);
    c_pwm_full: cover property (@(posedge CLK) pwm_mode && st.cmpa >= st.per);
    c_trig_start: cover property (@(posedge CLK) pulse_mode && !run && trg_rise);
    c_cap_period: cover property (@(posedge CLK) mode == MODE_CAP && match_p);
endmodule : ptpc_timer

/* verification/ptpc_pins.sv */
// far-side pin model: drives trigger and capture pins, samples the output pin
// assumes its tasks are entered just after a rising CLK edge
`timescale 1ns/1ps
module ptpc_pins (
    input wire logic CLK,
    input wire logic TIMER_OUT,
    input wire logic TIMER_OUT_EN,
    output logic EXT_TRIGGER_PIN,
    output logic CAPTURE_INPUT_PIN
);
    // a released pin is pulled up
    wire pin_level = TIMER_OUT_EN ? TIMER_OUT : 1'b1;
    initial begin
        EXT_TRIGGER_PIN = 1'b0;
        CAPTURE_INPUT_PIN = 1'b0;
    end
    // held three cycles so both edges reach the sampler
    task automatic pulse(input logic trig);
        if (trig) begin
            EXT_TRIGGER_PIN <= 1'b1;
        end else begin
            CAPTURE_INPUT_PIN <= 1'b1;
        end
        repeat (3) @(posedge CLK);
        EXT_TRIGGER_PIN <= 1'b0;
        CAPTURE_INPUT_PIN <= 1'b0;
        @(posedge CLK);
    endtask : pulse
    task automatic count_high(input int n, output int hi);
        hi = 0;
        // sampled on the falling edge, where the registered pin has settled
        repeat (n) begin
            @(negedge CLK);
            hi += (pin_level === 1'b1);
        end
    endtask : count_high
endmodule : ptpc_pins

/* verification/test_ptpc_timer.sv */
// self-checking bench for the periodic timer through apb
// assumes ptpc_pins stands at the trigger, capture and output pins
`timescale 1ns/1ps
module test_ptpc_timer
    import ptpc_pkg::*;
;
    logic CLK, ARST_N, PSEL, PENABLE, PWRITE, PREADY, PSLVERR;
    logic EXT_TRIGGER_PIN, CAPTURE_INPUT_PIN, TIMER_OUT, TIMER_OUT_EN, er;
    logic [11:0] PADDR;
    logic [31:0] PWDATA, PRDATA, rd, a;
    int fails = 0;
    int num_checks = 0;
    ptpc_timer u_ptpc_timer (.CLK, .ARST_N, .PSEL, .PENABLE, .PWRITE, .PADDR, .PWDATA,
        .PRDATA, .PREADY, .PSLVERR, .EXT_TRIGGER_PIN, .CAPTURE_INPUT_PIN, .TIMER_OUT,
        .TIMER_OUT_EN);
    ptpc_pins u_ptpc_pins (.CLK, .TIMER_OUT, .TIMER_OUT_EN, .EXT_TRIGGER_PIN,
        .CAPTURE_INPUT_PIN);
    task automatic finish_test;
        $display("checks %0d fails %0d", num_checks, fails);
        if (fails == 0 && num_checks > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask : finish_test
    task automatic check_val(input string nm, input logic [31:0] e, input logic [31:0] g);
        num_checks++;
        if (g !== e) begin
            fails++;
            $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
        end
    endtask : check_val
    task automatic check_cnt(input string nm, input int e, input int g);
        num_checks++;
        if (g != e) begin
            fails++;
            $display("CHECK FAILED %s expected %0d seen %0d", nm, e, g);
        end
    endtask : check_cnt
    // holds the request until pready is seen high; data and error are taken at that edge
    task automatic apb(input logic w, input logic [11:0] ad, input logic [31:0] wd);
        int n;
        PSEL <= 1'b1;
        PENABLE <= 1'b0;
        PWRITE <= w;
        PADDR <= ad;
        PWDATA <= wd;
        @(posedge CLK);
        PENABLE <= 1'b1;
        n = 0;
        do begin
            @(posedge CLK);
            n++;
        end while (PREADY !== 1'b1 && n < 50);
        if (PREADY !== 1'b1) begin
            fails++;
        end
        er = PSLVERR;
        rd = PRDATA;
        PSEL <= 1'b0;
        PENABLE <= 1'b0;
        // idle edge so the next call never reassigns psel in this time step
        @(posedge CLK);
    endtask : apb
    task automatic wr(input logic [11:0] ad, input logic [31:0] d);
        apb(1'b1, ad, d);
    endtask : wr
    task automatic rdr(input logic [11:0] ad);
        apb(1'b0, ad, 32'h0);
    endtask : rdr
    // b holds level, invert, capture source, clear source
    function automatic logic [31:0] ctl(input logic [1:0] m, input logic [1:0] p,
        input logic [3:0] b);
        ctl = {24'h0, m, p, b};
    endfunction : ctl
    task automatic pwm_run(input logic [31:0] c, input int n, input int e);
        int h;
        wr(OFS_CTRL, c);
        wr(OFS_CTRL, c | 32'h100);
        repeat (8) @(posedge CLK);
        u_ptpc_pins.count_high(n, h);
        check_cnt("pwm_high", e, h);
    endtask : pwm_run
    task automatic t_regs;
        rdr(OFS_CTRL);
        check_val("ctrl_rst", 32'h0, rd);
        apb(1'b0, 12'h020, 32'h0);
        check_val("unmapped_err", 32'h1, er);
        check_val("unmapped_data", 32'h0, rd);
        wr(OFS_CNT, 32'h5);
        rdr(OFS_CNT);
        check_val("cnt_ro", 32'h0, rd);
        wr(OFS_CMPA, 32'hFFFFFFFF);
        rdr(OFS_CMPA);
        check_val("cmpa_width", 32'h3FF, rd);
    endtask : t_regs
    task automatic t_pwm;
        wr(OFS_PER, 32'h8);
        wr(OFS_CMPA, 32'h3);
        pwm_run(ctl(MODE_PWM, 2'h2, 4'h8), 32, 12);
        pwm_run(ctl(MODE_PWM, 2'h2, 4'h9), 32, 12);
        pwm_run(ctl(MODE_PWM, 2'h2, 4'h0), 32, 20);
        pwm_run(ctl(MODE_PWM, 2'h2, 4'hC), 32, 20);
        pwm_run(ctl(MODE_PWM, PIN_HIGH, 4'h8), 32, 32);
        pwm_run(ctl(MODE_PWM, PIN_LOW, 4'h8), 32, 0);
        rdr(OFS_CNT);
        a = rd;
        rdr(OFS_CNT);
        check_val("cnt_moves", 32'h1, a != rd);
        wr(OFS_FLAG, 32'h3);
        repeat (20) @(posedge CLK);
        rdr(OFS_FLAG);
        check_val("pwm_flags", 32'h3, rd);
        wr(OFS_CMPA, 32'h9);
        pwm_run(ctl(MODE_PWM, 2'h2, 4'h8), 32, 32);
        wr(OFS_PER, 32'h0);
        wr(OFS_CMPA, 32'h200);
        pwm_run(ctl(MODE_PWM, 2'h2, 4'h8), 1024, 512);
    endtask : t_pwm
    task automatic t_pulse;
        wr(OFS_CMPA, 32'hC8);
        wr(OFS_CTRL, ctl(MODE_PWM, PIN_NONE, 4'h8));
        wr(OFS_FLAG, 32'h3);
        u_ptpc_pins.pulse(1'b1);
        rdr(OFS_CTRL);
        check_val("trig_run", 32'h1, rd[8]);
        check_val("pulse_lead", 32'h1, TIMER_OUT);
        repeat (220) @(posedge CLK);
        rdr(OFS_CTRL);
        check_val("auto_stop", 32'h0, rd[8]);
        check_val("pulse_trail", 32'h0, TIMER_OUT);
        rdr(OFS_FLAG);
        check_val("pulse_flag", 32'h1, rd[0]);
        wr(OFS_CTRL, ctl(MODE_PWM, PIN_NONE, 4'h8) | 32'h100);
        rdr(OFS_CNT);
        check_val("cnt_restart", 32'h1, rd < 12);
        check_val("sw_lead", 32'h1, TIMER_OUT);
        wr(OFS_CTRL, ctl(MODE_PWM, PIN_NONE, 4'h8));
        repeat (3) @(posedge CLK);
        check_val("sw_trail", 32'h0, TIMER_OUT);
    endtask : t_pulse
    task automatic t_capture;
        wr(OFS_PER, 32'h3E8);
        for (int s = 0; s < 2; s++) begin
            for (int p = 0; p < 4; p++) begin
                a = ctl(MODE_CAP, p[1:0], {2'h3, s[0], 1'b0});
                wr(OFS_CTRL, a);
                wr(OFS_CMPA, 32'h0);
                wr(OFS_FLAG, 32'h3);
                wr(OFS_CTRL, a | 32'h100);
                repeat (20) @(posedge CLK);
                u_ptpc_pins.pulse(s == 0);
                rdr(OFS_FLAG);
                check_val("cap_other", 32'h0, rd[0]);
                u_ptpc_pins.pulse(s == 1);
                rdr(OFS_FLAG);
                check_val("cap_flag", {31'h0, p != 3}, rd[0]);
                rdr(OFS_CMPA);
                check_val("cap_value", {31'h0, p != 3}, rd != 0);
                rdr(OFS_CNT);
                check_val("cap_runs", 32'h1, rd != 0);
                check_val("cap_no_out", 32'h0, TIMER_OUT_EN);
            end
        end
        wr(OFS_PER, 32'h32);
        // the counter may already be past the new period, so let it wrap once
        repeat (1100) @(posedge CLK);
        rdr(OFS_CNT);
        check_val("cap_wrap", 32'h1, rd <= 32'h32);
        rdr(OFS_FLAG);
        check_val("cap_per_flag", 32'h1, rd[1]);
    endtask : t_capture
    task automatic t_timer;
        wr(OFS_CTRL, ctl(MODE_TMR, 2'h2, 4'h0));
        wr(OFS_PER, 32'hA);
        wr(OFS_CMPA, 32'h4);
        wr(OFS_FLAG, 32'h3);
        wr(OFS_CTRL, ctl(MODE_TMR, 2'h2, 4'h0) | 32'h100);
        repeat (40) @(posedge CLK);
        rdr(OFS_FLAG);
        check_val("tmr_flags", 32'h3, rd);
        check_val("tmr_no_out", 32'h0, TIMER_OUT_EN);
        wr(OFS_CTRL, ctl(MODE_TMR, 2'h2, 4'h1));
        wr(OFS_PER, 32'h2);
        wr(OFS_CMPA, 32'h6);
        wr(OFS_FLAG, 32'h3);
        wr(OFS_CTRL, ctl(MODE_TMR, 2'h2, 4'h1) | 32'h100);
        repeat (40) @(posedge CLK);
        rdr(OFS_FLAG);
        check_val("clr_a_flags", 32'h1, rd);
        rdr(OFS_CNT);
        check_val("clr_a_cnt", 32'h1, rd <= 32'h6);
        wr(OFS_CTRL, ctl(MODE_TMR, 2'h2, 4'h0));
        wr(OFS_PER, 32'h0);
        wr(OFS_CMPA, 32'h0);
        wr(OFS_FLAG, 32'h3);
        wr(OFS_CTRL, ctl(MODE_TMR, 2'h2, 4'h0) | 32'h100);
        repeat (1100) @(posedge CLK);
        rdr(OFS_CNT);
        check_val("wrap_cnt", 32'h1, rd < 32'h64);
    endtask : t_timer
    initial begin
        CLK = 1'b0;
        forever #2 CLK = ~CLK;
    end
    initial begin
        #200000;
        fails++;
        finish_test();
    end
    initial begin
        {ARST_N, PSEL, PENABLE, PWRITE} = 4'h0;
        PADDR = 12'h000;
        PWDATA = 32'h0;
        repeat (6) @(posedge CLK);
        ARST_N <= 1'b1;
        @(posedge CLK);
        t_regs();
        t_pwm();
        t_pulse();
        t_capture();
        t_timer();
        finish_test();
    end
endmodule : test_ptpc_timer
